// [hw/prc_map.svh]
/*
  Command codes, parameter field positions and reset values for the
  panel resolution configuration block.
  Assumes 8-bit command and parameter bytes on the command interface.
*/
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH

`define PRC_CMD_SW_RESET 8'h01
`define PRC_CMD_RES_HIGH 8'hd0
`define PRC_CMD_WIDTH_LOW 8'hd1
`define PRC_CMD_HEIGHT_LOW 8'hd2
`define PRC_CMD_OFFSET 8'hdd

`define PRC_RST_RES_HIGH 8'h91
`define PRC_RST_WIDTH_LOW 8'h68
`define PRC_RST_HEIGHT_LOW 8'h86
`define PRC_RST_OFFSET 8'h40

`define PRC_BIT_DUAL_GATE 7
`define PRC_BIT_AMP_REDUCE 6
`define PRC_BIT_WIDTH_HIGH 4
`define PRC_HEIGHT_HIGH_MSB 2
`define PRC_OFFSET_MSB 6
`define PRC_OFFSET_BIAS 8'h40

`endif

// [hw/prc_pkg.sv]
/*
  Types shared by the panel resolution configuration block.
  Assumes prc_map.svh supplies the numeric constants.
*/
package prc_pkg;
  typedef enum logic [1:0] {PRC_IDLE, PRC_ARMED, PRC_SPENT} prc_state_e;
  typedef logic [7:0] prc_byte_t;
  typedef logic signed [7:0] prc_adj_t;
endpackage

// [hw/prc_regs.sv]
/*
  Command-addressed resolution and common-voltage offset registers.
  Assumes the host drives the 8-bit command bus pins asynchronously to mclk
  and holds data and select steady for at least three mclk periods
  around each rising edge of the write strobe.
*/
`timescale 1ns/1ns
`include "prc_map.svh"

module prc_regs
  import prc_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // command interface pins
  input wire logic data_command_select,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire prc_pkg::prc_byte_t cmd_data,
  // register contents
  output prc_pkg::prc_byte_t resolution_control_high,
  output prc_pkg::prc_byte_t source_width_low,
  output prc_pkg::prc_byte_t gate_height_low,
  output prc_pkg::prc_byte_t common_voltage_offset,
  // decoded panel settings
  output logic dual_gate,
  output logic source_amp_reduce,
  output logic [8:0] source_width,
  output logic [10:0] gate_height,
  // level shifts in offset steps
  output prc_pkg::prc_adj_t positive_gamma_adj,
  output prc_pkg::prc_adj_t negative_gamma_adj,
  output prc_pkg::prc_adj_t source_common_adj,
  output prc_pkg::prc_adj_t common_output_adj
);
  import prc_pkg::*;

  logic [10:0] pins_s1_q;
  logic [10:0] pins_s2_q;
  logic wr_prev_q;
  logic wr_edge;
  logic is_param;
  prc_byte_t bus_byte;
  prc_state_e state_q;
  prc_byte_t cmd_q;
  prc_byte_t res_high_q;
  prc_byte_t width_low_q;
  prc_byte_t height_low_q;
  prc_byte_t offset_q;
  prc_adj_t adj_q;
  prc_adj_t neg_adj_q;
  prc_adj_t com_adj_q;

  // offset code is an unsigned 7-bit value biased by 64
  function automatic prc_adj_t offset_adj(input prc_byte_t code);
    offset_adj = prc_adj_t'({1'b0, code[`PRC_OFFSET_MSB:0]} - `PRC_OFFSET_BIAS);
  endfunction

  // pins cross from the host's timing into mclk
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pins_s1_q <= 11'h7ff;
      pins_s2_q <= 11'h7ff;
      wr_prev_q <= 1'b1;
    end
    else if (ce)
    begin
      pins_s1_q <= {data_command_select, write_strobe_n, read_strobe_n, cmd_data};
      pins_s2_q <= pins_s1_q;
      wr_prev_q <= pins_s2_q[9];
    end
  end

  assign bus_byte = pins_s2_q[7:0];
  assign is_param = pins_s2_q[10];
  // a strobe edge with the read strobe low is a bus conflict and is dropped
  assign wr_edge = ce && pins_s2_q[9] && !wr_prev_q && pins_s2_q[8];

  // no display-mode gating: sleep, idle and partial states all accept writes
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= PRC_IDLE;
      cmd_q <= 8'h00;
    end
    else if (wr_edge)
    begin
      if (!is_param)
      begin
        cmd_q <= bus_byte;
        state_q <= PRC_ARMED;
      end
      else if (state_q == PRC_ARMED)
      begin
        // only the first parameter belongs to these one-byte commands
        state_q <= PRC_SPENT;
      end
    end
  end

  // every register takes its default on hardware or software reset
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      res_high_q <= `PRC_RST_RES_HIGH;
      neg_adj_q <= 8'sh00;
      width_low_q <= `PRC_RST_WIDTH_LOW;
      height_low_q <= `PRC_RST_HEIGHT_LOW;
      offset_q <= `PRC_RST_OFFSET;
      adj_q <= 8'sh00;
    end
    else if (wr_edge && !is_param && bus_byte == `PRC_CMD_SW_RESET)
    begin
      res_high_q <= `PRC_RST_RES_HIGH;
      neg_adj_q <= 8'sh00;
      width_low_q <= `PRC_RST_WIDTH_LOW;
      height_low_q <= `PRC_RST_HEIGHT_LOW;
      offset_q <= `PRC_RST_OFFSET;
      adj_q <= 8'sh00;
    end
    else if (wr_edge && is_param && state_q == PRC_ARMED)
    begin
      unique case (cmd_q)
        `PRC_CMD_RES_HIGH: res_high_q <= bus_byte;
        `PRC_CMD_WIDTH_LOW: width_low_q <= bus_byte;
        `PRC_CMD_HEIGHT_LOW: height_low_q <= bus_byte;
        `PRC_CMD_OFFSET:
        begin
          offset_q <= {1'b0, bus_byte[`PRC_OFFSET_MSB:0]};
          adj_q <= offset_adj(bus_byte);
          // own flop so the negative level leaves the block registered
          neg_adj_q <= prc_adj_t'(-offset_adj(bus_byte));
        end
        default:
        begin
          // commands owned by other blocks pass untouched
        end
      endcase
    end
  end

  // the common output never follows the offset code; held in a flop so that
  // every output of the block leaves from a register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      com_adj_q <= 8'sh00;
    end
    else if (ce)
    begin
      com_adj_q <= 8'sh00;
    end
  end

  // width and height legality is the host's duty; values are kept as written
  assign resolution_control_high = res_high_q;
  assign source_width_low = width_low_q;
  assign gate_height_low = height_low_q;
  assign common_voltage_offset = offset_q;
  assign dual_gate = res_high_q[`PRC_BIT_DUAL_GATE];
  assign source_amp_reduce = res_high_q[`PRC_BIT_AMP_REDUCE];
  assign source_width = {res_high_q[`PRC_BIT_WIDTH_HIGH], width_low_q};
  assign gate_height = {res_high_q[`PRC_HEIGHT_HIGH_MSB:0], height_low_q};
  assign positive_gamma_adj = adj_q;
  assign source_common_adj = adj_q;
  assign negative_gamma_adj = neg_adj_q;
  assign common_output_adj = com_adj_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence param_taken(logic [7:0] code);
    wr_edge && is_param && state_q == PRC_ARMED && cmd_q == code;
  endsequence

  sequence sw_reset_cmd;
    wr_edge && !is_param && bus_byte == `PRC_CMD_SW_RESET;
  endsequence

  sequence cmd_taken;
    wr_edge && !is_param;
  endsequence

  sequence stray_param;
    wr_edge && is_param && state_q != PRC_ARMED;
  endsequence

  cmd_arm_a: assert property (cmd_taken
    |=> state_q == PRC_ARMED && cmd_q == $past(bus_byte))
    else $error("command byte not latched");
  high_write_a: assert property (param_taken(`PRC_CMD_RES_HIGH)
    |=> resolution_control_high == $past(bus_byte))
    else $error("resolution control byte not stored");
  width_write_a: assert property (param_taken(`PRC_CMD_WIDTH_LOW)
    |=> source_width[7:0] == $past(bus_byte))
    else $error("width low byte not stored");
  height_write_a: assert property (param_taken(`PRC_CMD_HEIGHT_LOW)
    |=> gate_height[7:0] == $past(bus_byte))
    else $error("height low byte not stored");
  offset_shift_a: assert property (param_taken(`PRC_CMD_OFFSET)
    |=> positive_gamma_adj == $signed({1'b0, $past(bus_byte[6:0])}) - 8'sh40)
    else $error("offset shift wrong");
  level_mirror_a: assert property (negative_gamma_adj == -source_common_adj
    && common_output_adj == 8'sh00)
    else $error("offset levels not mirrored");
  soft_reset_a: assert property (sw_reset_cmd
    |=> resolution_control_high == `PRC_RST_RES_HIGH && source_width == 9'h168
    && gate_height == 11'h186 && positive_gamma_adj == 8'sh00
    && negative_gamma_adj == 8'sh00)
    else $error("software reset defaults wrong");
  amp_mode_a: assert property (source_amp_reduce == resolution_control_high[6]
    && dual_gate == resolution_control_high[7])
    else $error("mode bits not decoded");
  read_low_ignored_a: assert property (!pins_s2_q[8] |=> $stable(state_q)
    && $stable(source_width))
    else $error("write taken with read strobe low");
  stray_param_a: assert property (stray_param |=> $stable(source_width)
    && $stable(gate_height) && $stable(resolution_control_high)
    && $stable(common_voltage_offset))
    else $error("parameter taken without its command");
  freeze_a: assert property (!ce |=> $stable(resolution_control_high)
    && $stable(state_q) && $stable(common_voltage_offset))
    else $error("state moved while clock enable low");
endmodule

// [tb/prc_host_model.sv]
/*
  Host model that drives the command pins one byte at a time.
  Assumes a free running mclk and callers that start on a rising edge.
*/
`timescale 1ns/1ns
module prc_host_model
  import prc_pkg::*;
(
  // clock
  input wire logic mclk,
  // command pins
  output logic data_command_select,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output prc_pkg::prc_byte_t cmd_data
);
  initial
  begin
    data_command_select = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    cmd_data = 8'h00;
  end
  // rd low makes the device refuse the byte
  task automatic send(input logic sel, input prc_byte_t b, input logic rd);
    data_command_select <= sel;
    cmd_data <= b;
    read_strobe_n <= rd;
    repeat (4) @(posedge mclk);
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge mclk);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // released bus must not keep showing the byte
    cmd_data <= ~b;
    read_strobe_n <= 1'b1;
    @(posedge mclk);
  endtask
endmodule

// [tb/panel_resolution_config_tb.sv]
/*
  Self-checking bench for the resolution registers.
  Assumes the host model keeps strobe and data timing.
*/
`timescale 1ns/1ns
module panel_resolution_config_tb;
  import prc_pkg::*;
  logic mclk, reset, ce, dcs, wsn, rsn, dg, amp;
  prc_byte_t dat, r0, r1, r2, r3, m0, m1, m2, m3, p;
  logic [8:0] sw;
  logic [10:0] gh;
  prc_adj_t pa, na, sa, ca;
  int err_total, compares, cyc;
  logic pd, ps;
  logic [8:0] pw;
  logic [10:0] ph;
  prc_host_model host (.mclk(mclk), .data_command_select(dcs), .write_strobe_n(wsn),
    .read_strobe_n(rsn), .cmd_data(dat));
  prc_regs DUT (.mclk(mclk), .reset(reset), .ce(ce), .data_command_select(dcs),
    .write_strobe_n(wsn), .read_strobe_n(rsn), .cmd_data(dat),
    .resolution_control_high(r0), .source_width_low(r1), .gate_height_low(r2),
    .common_voltage_offset(r3), .dual_gate(dg), .source_amp_reduce(amp),
    .source_width(sw), .gate_height(gh), .positive_gamma_adj(pa),
    .negative_gamma_adj(na), .source_common_adj(sa), .common_output_adj(ca));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [10:0] got, input logic [10:0] ex);
    compares++;
    if (got !== ex)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, ex, got);
    end
  endtask
  function automatic prc_adj_t adj(input prc_byte_t c);
    return prc_adj_t'({1'b0, c[6:0]} - 8'h40);
  endfunction
  // a source width the host may program for the chosen gate and scroll setting
  function automatic logic [8:0] legal_width(input logic dual, input logic scroll,
    input int unsigned r);
    int unsigned step;
    int unsigned lo;
    step = 4;
    lo = 92;
    if (dual && scroll)
    begin
      step = 24;
      lo = 192;
    end
    else if (dual)
    begin
      step = 8;
      lo = 184;
    end
    else if (scroll)
    begin
      step = 12;
      lo = 96;
    end
    return 9'(lo + step * (r % ((511 - lo) / step + 1)));
  endfunction
  // settle past the edge, compare, then return to an edge for the next drive
  task automatic verify();
    #1;
    chk("res_high", r0, m0);
    chk("width_low", r1, m1);
    chk("height_low", r2, m2);
    chk("offset", r3, m3);
    chk("dual", dg, m0[7]);
    chk("amp", amp, m0[6]);
    chk("width", sw, {m0[4], m1});
    chk("height", gh, {m0[2:0], m2});
    chk("pos_adj", pa, adj(m3));
    chk("neg_adj", na, -adj(m3));
    chk("vsf_adj", sa, adj(m3));
    chk("com_adj", ca, 11'h000);
    @(posedge mclk);
  endtask
  task automatic dflt();
    m0 = 8'h91;
    m1 = 8'h68;
    m2 = 8'h86;
    m3 = 8'h40;
  endtask
  task automatic wr(input prc_byte_t c, input prc_byte_t b);
    host.send(1'b0, c, 1'b1);
    host.send(1'b1, b, 1'b1);
    case (c)
      8'hd0: m0 = b;
      8'hd1: m1 = b;
      8'hd2: m2 = b;
      8'hdd: m3 = {1'b0, b[6:0]};
      default: ;
    endcase
  endtask
  initial
  begin
    reset = 1'b1;
    ce = 1'b1;
    void'($urandom(32'h661b));
    dflt();
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    verify();
    for (int i = 0; i < 16; i++)
    begin
      pd = 1'($urandom);
      ps = 1'($urandom);
      pw = legal_width(pd, ps, $urandom);
      ph = 11'(10 + $urandom_range(2037));
      p = {pd, 1'($urandom), 1'($urandom), pw[8], 1'($urandom), ph[10:8]};
      wr(8'hd0, p);
      verify();
      wr(8'hd1, pw[7:0]);
      verify();
      wr(8'hd2, ph[7:0]);
      verify();
      wr(8'hd3 + 8'($urandom_range(9)), 8'($urandom));
      verify();
      wr(8'hdd, 8'($urandom));
      verify();
    end
    host.send(1'b0, 8'hd1, 1'b0);
    host.send(1'b1, ~m1, 1'b0);
    wr(8'hc9, 8'($urandom));
    verify();
    wr(8'hd2, 8'h0a);
    host.send(1'b1, 8'hff, 1'b1);
    verify();
    host.send(1'b0, 8'h01, 1'b1);
    dflt();
    repeat (4) @(posedge mclk);
    verify();
    wr(8'hdd, 8'hff);
    verify();
    // a whole write while frozen must leave no trace
    ce <= 1'b0;
    host.send(1'b0, 8'hd1, 1'b1);
    host.send(1'b1, ~m1, 1'b1);
    ce <= 1'b1;
    verify();
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    dflt();
    repeat (4) @(posedge mclk);
    verify();
    summarize();
  end
endmodule
